// ===== verilog/rrpc_pkg.sv
// Package for the reset retention and link event counter block.
// Assumes a core clock of 125 MHz and a synchronous active-high reset.
package rrpc_pkg;
  // Register map, one word per index, byte address is four times the index
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GEOM = 8'h08;
  localparam logic [7:0] ADDR_STBY = 8'h0C;
  localparam logic [7:0] ADDR_MULT = 8'h10;
  localparam logic [7:0] ADDR_MAXLBA_LO = 8'h14;
  localparam logic [7:0] ADDR_MAXLBA_HI = 8'h18;
  localparam logic [7:0] ADDR_XFER = 8'h1C;
  localparam logic [7:0] ADDR_APM = 8'h20;
  localparam logic [7:0] ADDR_SEC = 8'h24;
  localparam logic [7:0] ADDR_SERR_RD = 8'h28;
  localparam logic [7:0] ADDR_SERR_WR = 8'h2C;
  localparam logic [7:0] ADDR_IDENT76 = 8'h30;
  localparam logic [7:0] ADDR_LOG_BASE = 8'h40;
  // SET FEATURES subcommand codes
  localparam logic [7:0] SF_WCACHE_EN = 8'h02;
  localparam logic [7:0] SF_XFER_MODE = 8'h03;
  localparam logic [7:0] SF_APM_EN = 8'h05;
  localparam logic [7:0] SF_PRESERVE_EN = 8'h06;
  localparam logic [7:0] SF_PRESERVE_DIS = 8'h86;
  localparam logic [7:0] SF_RLA_EN = 8'hAA;
  localparam logic [7:0] SF_RLA_DIS = 8'h55;
  localparam logic [7:0] SF_REVERT_EN = 8'hCC;
  localparam logic [7:0] SF_REVERT_DIS = 8'h66;
  localparam logic [7:0] SF_WCACHE_DIS = 8'h82;
  localparam logic [7:0] SF_APM_DIS = 8'h85;
  // Log page and counter layout
  localparam logic [7:0] LOG_PAGE_CNT = 8'h11;
  localparam int NUM_CNT = 7;
  localparam logic [3:0] ID_W32 = 4'h2;
  localparam logic [11:0] ID_END = 12'h000;
  localparam logic [15:0] IDENT76_CNT_BIT = 16'h0400;
  // Hardware-reset defaults
  localparam logic [31:0] DEF_GEOM = 32'h0000_0000;
  localparam logic [7:0] DEF_STBY = 8'h00;
  localparam logic [7:0] DEF_MULT = 8'h10;
  localparam logic [7:0] DEF_XFER = 8'h00;
  localparam logic [7:0] DEF_APM = 8'h80;
  localparam logic [2:0] DEF_UNLOCK_CNT = 3'h5;
  localparam logic [2:0] SEC_UNLOCKED = 3'h5;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
endpackage : rrpc_pkg

// ===== verilog/rrpc_top.sv
// Settings retention across link hard reset plus link event counters.
// Commands arrive decoded as one-cycle strobes from the command layer;
// the counter log is read by firmware through the register port.
// Assumes resets and all strobes are synchronous to clk; reg_wr and
// reg_wdata are taken but no register here is writable.
// Counters are volatile: power-on reset, BIST activate and clear-after-read clear them; link and soft reset do not.
`timescale 1ns/100ps

module rrpc_top (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // Link hard reset and software reset pulses
  input wire logic comreset,
  input wire logic soft_reset,
  // Decoded command strobes
  input wire logic set_features,
  input wire logic [7:0] feat_code,
  input wire logic [7:0] sect_count,
  input wire logic init_params,
  input wire logic [31:0] geom_val,
  input wire logic set_stby,
  input wire logic [7:0] stby_val,
  input wire logic set_mult,
  input wire logic [7:0] mult_val,
  input wire logic set_max,
  input wire logic [47:0] max_lba_val,
  input wire logic sec_state_we,
  input wire logic [2:0] sec_state_val,
  input wire logic freeze_lock,
  input wire logic unlock_fail,
  input wire logic serr_rd_we,
  input wire logic serr_wr_we,
  input wire logic [31:0] serr_val,
  // Link events
  input wire logic ev_icrc_fail,
  input wire logic ev_rerr_data,
  input wire logic ev_rerr_ndata,
  input wire logic ev_phy_rdy,
  input wire logic ev_sig_fis,
  input wire logic ev_crc_h2d,
  input wire logic ev_nocrc_h2d,
  input wire logic bist_activate,
  // Counter log read request and completion
  input wire logic log_read,
  input wire logic [7:0] log_page,
  input wire logic [7:0] log_features,
  input wire logic log_done,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Settings outputs
  output logic preserve_en,
  output logic wcache_en,
  output logic rla_en,
  output logic revert_en,
  output logic apm_en,
  output logic [7:0] apm_level,
  output logic [7:0] xfer_mode,
  output logic [2:0] sec_state,
  output logic frozen,
  output logic [2:0] unlock_cnt
);

  // Preservation enable and SET FEATURES flags
  logic preserve_ff;
  logic wcache_ff;
  logic rla_ff;
  logic revert_ff;
  logic apm_en_ff;
  logic [7:0] apm_lvl_ff;
  logic [7:0] xfer_ff;
  // Command-programmed values
  logic [31:0] geom_ff;
  logic [7:0] stby_ff;
  logic [7:0] mult_ff;
  logic [47:0] maxlba_ff;
  logic [31:0] serr_rd_ff;
  logic [31:0] serr_wr_ff;
  // Security state, freeze flag and unlock attempts left
  logic [2:0] sec_ff;
  logic frozen_ff;
  logic [2:0] unl_ff;
  // Link event counters and their identifiers
  logic clear_pend_ff;
  logic [31:0] cnt_ff [rrpc_pkg::NUM_CNT];
  logic [rrpc_pkg::NUM_CNT-1:0] ev_vec;
  logic [11:0] cnt_id [rrpc_pkg::NUM_CNT];
  // Reset and clear qualifiers
  logic settings_rst;
  logic cnt_clr;
  // Register read path
  logic [31:0] nxt_rdata;

  // Hardware reset of settings: power-on, or link reset with preservation off
  // A link reset can arrive unasked on a loss of signal, which is why the
  // preservation flag gates it here and nowhere else.
  // Security state and counters do not use this path at all.
  assign settings_rst = rst | (comreset & ~preserve_ff);

  // Preservation enable; only power-on reset touches it
  // A link or soft reset leaves it as the host last set it, so retention
  // stays armed through an unexpected reset.
  // Enable and disable codes never meet in one strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      preserve_ff <= 1'b1;
    end else if (set_features && feat_code == rrpc_pkg::SF_PRESERVE_EN) begin
      preserve_ff <= 1'b1;
    end else if (set_features && feat_code == rrpc_pkg::SF_PRESERVE_DIS) begin
      preserve_ff <= 1'b0;
    end
  end

  // SET FEATURES flags kept over link reset when preserved
  // One code is decoded per strobe; unknown codes change nothing
  always_ff @(posedge clk) begin
    if (settings_rst) begin
      wcache_ff <= 1'b1;
      rla_ff <= 1'b1;
      revert_ff <= 1'b0;
      apm_en_ff <= 1'b0;
      apm_lvl_ff <= rrpc_pkg::DEF_APM;
      xfer_ff <= rrpc_pkg::DEF_XFER;
    end else if (set_features) begin
      case (feat_code)
        rrpc_pkg::SF_WCACHE_EN: begin
          wcache_ff <= 1'b1;
        end
        rrpc_pkg::SF_WCACHE_DIS: begin
          wcache_ff <= 1'b0;
        end
        rrpc_pkg::SF_XFER_MODE: begin
          xfer_ff <= sect_count;
        end
        rrpc_pkg::SF_APM_EN: begin
          apm_en_ff <= 1'b1;
          apm_lvl_ff <= sect_count;
        end
        rrpc_pkg::SF_APM_DIS: begin
          // Level is left as it was; only the enable drops
          apm_en_ff <= 1'b0;
        end
        rrpc_pkg::SF_RLA_EN: begin
          rla_ff <= 1'b1;
        end
        rrpc_pkg::SF_RLA_DIS: begin
          rla_ff <= 1'b0;
        end
        rrpc_pkg::SF_REVERT_EN: begin
          revert_ff <= 1'b1;
        end
        rrpc_pkg::SF_REVERT_DIS: begin
          revert_ff <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Geometry, standby, multiple, max address, stream logs
  // Only supported commands get storage; no others are held here
  always_ff @(posedge clk) begin
    if (settings_rst) begin
      geom_ff <= rrpc_pkg::DEF_GEOM;
      stby_ff <= rrpc_pkg::DEF_STBY;
      mult_ff <= rrpc_pkg::DEF_MULT;
      maxlba_ff <= '1;
      serr_rd_ff <= '0;
      serr_wr_ff <= '0;
    end else begin
      // Strobes are independent and may share a cycle
      if (init_params) begin
        geom_ff <= geom_val;
      end
      if (set_stby) begin
        stby_ff <= stby_val;
      end
      if (set_mult) begin
        mult_ff <= mult_val;
      end
      if (set_max) begin
        maxlba_ff <= max_lba_val;
      end
      if (serr_rd_we) begin
        serr_rd_ff <= serr_val;
      end
      if (serr_wr_we) begin
        serr_wr_ff <= serr_val;
      end
    end
  end

  // Security state, freeze and attempt counter
  // Only power-on reset sets them up: a link reset must never shift the
  // security state, with or without preservation, so an unlocked drive
  // cannot turn locked after a loss of signal.
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_ff <= rrpc_pkg::SEC_UNLOCKED;
      frozen_ff <= 1'b0;
      unl_ff <= rrpc_pkg::DEF_UNLOCK_CNT;
    end else begin
      if (sec_state_we) begin
        sec_ff <= sec_state_val;
      end
      if (freeze_lock) begin
        frozen_ff <= 1'b1;
      end
      // The count stops at zero rather than wrapping back to full
      if (unlock_fail && unl_ff != 3'h0) begin
        unl_ff <= unl_ff - 3'h1;
      end
    end
  end

  // Event vector; bidirectional counters take their own event line
  assign ev_vec = {ev_nocrc_h2d, ev_crc_h2d, ev_sig_fis, ev_phy_rdy,
                   ev_rerr_ndata, ev_rerr_data, ev_icrc_fail};
  // Identifier numbers: 001h and 00Ah mandatory, the rest optional
  // Log order is free, so it follows the event vector bit order
  // Id 001h: interface CRC failures of commands
  assign cnt_id[0] = 12'h001;
  // Id 002h: data frame retries asked, both directions
  assign cnt_id[1] = 12'h002;
  // Id 005h: non-data frame retries asked, both directions
  assign cnt_id[2] = 12'h005;
  // Id 009h: phy returns to ready
  assign cnt_id[3] = 12'h009;
  // Id 00Ah: reset signatures sent after a link reset
  assign cnt_id[4] = 12'h00A;
  // Id 00Bh: inbound frames refused for CRC
  assign cnt_id[5] = 12'h00B;
  // Id 00Dh: inbound frames refused for other errors
  assign cnt_id[6] = 12'h00D;

  // Clear-after-read: armed by a log read with bit 0, fired at completion
  // Waiting for log_done means the page carries the values seen before
  // the clear, never a half-cleared set.
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_pend_ff <= 1'b0;
    end else if (log_read && log_page == rrpc_pkg::LOG_PAGE_CNT) begin
      clear_pend_ff <= log_features[0];
    end else if (log_done) begin
      clear_pend_ff <= 1'b0;
    end
  end
  assign cnt_clr = bist_activate | (log_done & clear_pend_ff);

  // Counters: power-on reset, BIST activate and clear-after-read clear them, link and soft reset do not
  // A clear in the same cycle as an event wins; that event is lost.
  // Counters stop at all ones instead of wrapping to zero.
  generate
    for (genvar i = 0; i < rrpc_pkg::NUM_CNT; i++) begin : g_cnt
      always_ff @(posedge clk) begin
        // Power-on reset and both host clears share one branch
        if (rst || cnt_clr) begin
          cnt_ff[i] <= '0;
        end else if (ev_vec[i] && cnt_ff[i] != rrpc_pkg::CNT_MAX) begin
          cnt_ff[i] <= cnt_ff[i] + 32'h1;
        end
      end
    end
  endgenerate

  // Read mux; log words: 0 reserved, then id/value pairs, then end marker
  // Unmapped addresses read as zero, as does any log word past the end
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr == rrpc_pkg::ADDR_CTRL) begin
      nxt_rdata = {31'h0, preserve_ff};
    end else if (reg_addr == rrpc_pkg::ADDR_STATUS) begin
      nxt_rdata = {24'h0, clear_pend_ff, frozen_ff, revert_ff, rla_ff,
                   wcache_ff, apm_en_ff, 1'b0, preserve_ff};
      // Values kept by their own commands
    end else if (reg_addr == rrpc_pkg::ADDR_GEOM) begin
      nxt_rdata = geom_ff;
    end else if (reg_addr == rrpc_pkg::ADDR_STBY) begin
      nxt_rdata = {24'h0, stby_ff};
    end else if (reg_addr == rrpc_pkg::ADDR_MULT) begin
      nxt_rdata = {24'h0, mult_ff};
      // Max address, split over two words
    end else if (reg_addr == rrpc_pkg::ADDR_MAXLBA_LO) begin
      nxt_rdata = maxlba_ff[31:0];
    end else if (reg_addr == rrpc_pkg::ADDR_MAXLBA_HI) begin
      nxt_rdata = {16'h0, maxlba_ff[47:32]};
      // Feature values
    end else if (reg_addr == rrpc_pkg::ADDR_XFER) begin
      nxt_rdata = {24'h0, xfer_ff};
    end else if (reg_addr == rrpc_pkg::ADDR_APM) begin
      nxt_rdata = {23'h0, apm_en_ff, apm_lvl_ff};
      // Security word: attempts left, frozen, state
    end else if (reg_addr == rrpc_pkg::ADDR_SEC) begin
      nxt_rdata = {25'h0, unl_ff, frozen_ff, sec_ff};
      // Stream error logs
    end else if (reg_addr == rrpc_pkg::ADDR_SERR_RD) begin
      nxt_rdata = serr_rd_ff;
    end else if (reg_addr == rrpc_pkg::ADDR_SERR_WR) begin
      nxt_rdata = serr_wr_ff;
      // Identify word with the counter support bit
    end else if (reg_addr == rrpc_pkg::ADDR_IDENT76) begin
      nxt_rdata = {16'h0, rrpc_pkg::IDENT76_CNT_BIT};
    end else if (reg_addr >= rrpc_pkg::ADDR_LOG_BASE) begin
      // Word k: 0 reserved, 2i+1 id, 2i+2 value, 2N+1 end marker
      for (int i = 0; i < rrpc_pkg::NUM_CNT; i++) begin
        if (reg_addr == rrpc_pkg::ADDR_LOG_BASE + 8'((2*i+1)*4)) begin
          nxt_rdata = {16'h0, 1'b0, rrpc_pkg::ID_W32[2:0], cnt_id[i]};
        end
        if (reg_addr == rrpc_pkg::ADDR_LOG_BASE + 8'((2*i+2)*4)) begin
          nxt_rdata = cnt_ff[i];
        end
      end
      if (reg_addr == rrpc_pkg::ADDR_LOG_BASE +
          8'((2*rrpc_pkg::NUM_CNT+1)*4)) begin
        nxt_rdata = {20'h0, rrpc_pkg::ID_END};
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  // Holding zero between reads keeps the bus quiet for a shared mux
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : 32'h0;
    end
  end

  // Settings leave the block straight from their flops
  // The register port is read-only: reg_wr and reg_wdata change nothing,
  // so preservation stays under host command control alone.
  // The soft_reset input is taken and ignored: nothing here clears on it.
  // Feature flags
  assign preserve_en = preserve_ff;
  assign wcache_en = wcache_ff;
  assign rla_en = rla_ff;
  assign revert_en = revert_ff;
  assign apm_en = apm_en_ff;
  assign apm_level = apm_lvl_ff;
  assign xfer_mode = xfer_ff;
  // Security outputs
  assign sec_state = sec_ff;
  assign frozen = frozen_ff;
  assign unlock_cnt = unl_ff;

endmodule : rrpc_top

// ===== test/rrpc_monitor.sv
// Checker for settings retention and counter block top ports.
// Assumes bind to rrpc_top; one clock, sync active-high rst.
`timescale 1ns/100ps
module rrpc_monitor (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic comreset,
  // Commands
  input wire logic set_features,
  input wire logic [7:0] feat_code,
  input wire logic [7:0] sect_count,
  input wire logic sec_state_we,
  input wire logic freeze_lock,
  input wire logic unlock_fail,
  input wire logic reg_rd,
  // Outputs watched
  input wire logic [31:0] reg_rdata,
  input wire logic preserve_en,
  input wire logic wcache_en,
  input wire logic rla_en,
  input wire logic revert_en,
  input wire logic apm_en,
  input wire logic [7:0] apm_level,
  input wire logic [7:0] xfer_mode,
  input wire logic [2:0] sec_state,
  input wire logic frozen,
  input wire logic [2:0] unlock_cnt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic sf;
  // Lone feature command, no hard reset beside it
  assign sf = set_features && !comreset;
  a_pres_on: assert property ($fell(rst) |-> preserve_en)
    else $error("preservation off after power-on");
  a_pres_cmd: assert property (sf && feat_code == 8'h06 |=> preserve_en)
    else $error("preservation enable ignored");
  a_wcache_cmd: assert property (sf && (feat_code == 8'h02 ||
    feat_code == 8'h82) |=> wcache_en == ($past(feat_code) == 8'h02))
    else $error("write cache setting wrong");
  a_rla_cmd: assert property (sf && (feat_code == 8'hAA ||
    feat_code == 8'h55) |=> rla_en == ($past(feat_code) == 8'hAA))
    else $error("look-ahead setting wrong");
  a_apm_level: assert property (sf && feat_code == 8'h05 |=>
    apm_en && apm_level == $past(sect_count))
    else $error("power level not taken");
  a_keep_on_reset: assert property (comreset && preserve_en && !set_features
    |=> $stable({wcache_en, rla_en, revert_en, apm_en, apm_level,
    xfer_mode}))
    else $error("settings lost on link reset");
  a_sec_kept: assert property (comreset && !sec_state_we && !freeze_lock
    && !unlock_fail |=> $stable({sec_state, frozen, unlock_cnt}))
    else $error("security state moved on link reset");
  a_defaults_back: assert property (comreset && !preserve_en && !set_features
    |=> wcache_en && rla_en && !revert_en && !apm_en
    && apm_level == 8'h80 && xfer_mode == 8'h00)
    else $error("defaults not restored");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule : rrpc_monitor

bind rrpc_top rrpc_monitor u_mon (.clk, .rst, .comreset, .set_features,
  .feat_code, .sect_count, .sec_state_we, .freeze_lock, .unlock_fail,
  .reg_rd, .reg_rdata, .preserve_en, .wcache_en, .rla_en, .revert_en,
  .apm_en, .apm_level, .xfer_mode, .sec_state, .frozen, .unlock_cnt);

// ===== test/rrpc_host_model.sv
// Host controller model: issues feature commands and link resets.
// Assumes the bench calls its tasks; drives just after rising edges.
`timescale 1ns/100ps
module rrpc_host_model (
  // Clock
  input wire logic clk,
  // Command and reset lines
  output logic set_features,
  output logic [7:0] feat_code,
  output logic [7:0] sect_count,
  output logic comreset,
  output logic soft_reset
);
  initial begin
    {set_features, feat_code, sect_count, comreset, soft_reset} = '0;
  end
  // One-cycle feature command with its count byte
  task sf(input logic [7:0] code, input logic [7:0] cnt);
    @(posedge clk);
    set_features <= 1'b1;
    feat_code <= code;
    sect_count <= cnt;
    @(posedge clk);
    set_features <= 1'b0;
    feat_code <= ~code; // Stale bus must not look valid
  endtask : sf
  // Link hard reset and software reset together
  task hard();
    @(posedge clk);
    comreset <= 1'b1;
    soft_reset <= 1'b1;
    @(posedge clk);
    comreset <= 1'b0;
    soft_reset <= 1'b0;
  endtask : hard
endmodule : rrpc_host_model

// ===== test/tb.sv
// Self-checking bench for the retention and link counter block.
// Assumes rrpc_pkg and rrpc_top compiled first; 125 MHz clock.
`timescale 1ns/100ps
module tb;
  logic clk = 0, rst = 1;
  logic [18:0] st = '0;
  logic [7:0] reg_addr = '0, log_page = 8'h11, log_features = 8'h01;
  logic reg_rd = 0, reg_wr = 0;
  logic [31:0] reg_wdata = '0, ev32 = 32'h0000_00A5;
  logic [2:0] sv = 3'h6;
  logic [31:0] reg_rdata, d;
  logic sfe, crs, srs;
  logic [7:0] fc, sc, apm_level, xfer_mode;
  logic pe, wc, rl, rv, ae, fz;
  logic [2:0] ss, uc;
  int errors = 0, n_tests = 0, cyc = 0;
  initial forever #4 clk = ~clk;
  rrpc_host_model host (.clk(clk), .set_features(sfe), .feat_code(fc),
    .sect_count(sc), .comreset(crs), .soft_reset(srs));
  rrpc_top dut (.clk(clk), .rst(rst), .comreset(crs), .soft_reset(srs),
    .set_features(sfe), .feat_code(fc), .sect_count(sc),
    .init_params(st[8]), .geom_val(32'h1234_5678), .set_stby(st[9]),
    .stby_val(8'h2A), .set_mult(st[10]), .mult_val(8'h08),
    .set_max(st[11]), .max_lba_val(48'h0ABC_0123_4567),
    .sec_state_we(st[12]), .sec_state_val(sv), .freeze_lock(st[13]),
    .unlock_fail(st[14]), .serr_rd_we(st[15]), .serr_wr_we(st[16]),
    .serr_val(ev32), .ev_icrc_fail(st[0]),
    .ev_rerr_data(st[1]), .ev_rerr_ndata(st[2]), .ev_phy_rdy(st[3]),
    .ev_sig_fis(st[4]), .ev_crc_h2d(st[5]), .ev_nocrc_h2d(st[6]),
    .bist_activate(st[7]), .log_read(st[17]), .log_page(log_page),
    .log_features(log_features), .log_done(st[18]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .preserve_en(pe),
    .wcache_en(wc), .rla_en(rl), .revert_en(rv), .apm_en(ae),
    .apm_level(apm_level), .xfer_mode(xfer_mode), .sec_state(ss),
    .frozen(fz), .unlock_cnt(uc));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Register read: data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Register write: one cycle, strobe beside address and data
  task wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task p(input int b);
    @(posedge clk);
    st[b] <= 1'b1;
    @(posedge clk);
    st[b] <= 1'b0;
  endtask : p
  task set_chk(input logic [31:0] e, input logic [31:0] s);
    repeat (2) @(posedge clk);
    #1;
    chk({wc, rl, rv, ae, apm_level, xfer_mode}, e);
    chk({ss, fz, uc}, s);
  endtask : set_chk
  task results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    set_chk({4'b1100, 8'h80, 8'h00}, {3'h5, 1'b0, 3'h5});
    chk(pe, 1'b1);
    rd(8'h30, 32'h0000_0400);
    // Register port is read-only: a write must not clear preservation
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0001);
    // Program every protected setting, then a link reset
    host.sf(8'h82, 8'h00);
    host.sf(8'h55, 8'h00);
    host.sf(8'hCC, 8'h00);
    host.sf(8'h05, 8'h3C);
    host.sf(8'h03, 8'h45);
    for (int b = 8; b <= 15; b++) p(b);
    ev32 <= 32'h0000_005A;
    p(16);
    host.hard();
    set_chk({4'b0011, 8'h3C, 8'h45}, {3'h6, 1'b1, 3'h4});
    rd(8'h08, 32'h1234_5678);
    rd(8'h0C, 32'h0000_002A);
    rd(8'h10, 32'h0000_0008);
    rd(8'h28, 32'h0000_00A5);
    rd(8'h2C, 32'h0000_005A);
    rd(8'h14, 32'h0123_4567);
    rd(8'h18, 32'h0000_0ABC);
    // Counters survive link and soft reset; log layout; clear after read
    repeat (3) p(0);
    host.hard();
    rd(8'h44, 32'h0000_2001);
    rd(8'h48, 32'h0000_0003);
    rd(8'h64, 32'h0000_200A);
    rd(8'h74, 32'h0000_200D);
    rd(8'h7C, 32'h0000_0000);
    p(17);
    rd(8'h48, 32'h0000_0003);
    p(18);
    rd(8'h48, 32'h0000_0000);
    repeat (2) p(5);
    rd(8'h70, 32'h0000_0002);
    // Without features bit 0 a log read leaves the counters alone
    log_features <= 8'h00;
    p(17);
    p(18);
    rd(8'h70, 32'h0000_0002);
    p(7);
    rd(8'h70, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    // Preservation off: defaults return, security untouched
    host.sf(8'h86, 8'h00);
    host.hard();
    set_chk({4'b1100, 8'h80, 8'h00}, {3'h6, 1'b1, 3'h4});
    chk(pe, 1'b0);
    rd(8'h10, 32'h0000_0010);
    rd(8'h28, 32'h0000_0000);
    host.sf(8'h06, 8'h00);
    @(posedge clk);
    #1 chk(pe, 1'b1);
    // Every remaining code: cache and look-ahead disabled then enabled, revert and APM enabled then disabled
    host.sf(8'h82, 8'h00);
    host.sf(8'h02, 8'h00);
    host.sf(8'h55, 8'h00);
    host.sf(8'hAA, 8'h00);
    host.sf(8'hCC, 8'h00);
    host.sf(8'h66, 8'h00);
    host.sf(8'h05, 8'h11);
    host.sf(8'h85, 8'h00);
    set_chk({4'b1100, 8'h11, 8'h00}, {3'h6, 1'b1, 3'h4});
    results();
  end
endmodule : tb
